// ===== olb_pkg.sv
// Constants shared by the overlay layer blender files
package olb_pkg;

   // -------------------------------------------------------------------
   // Register byte addresses
   // -------------------------------------------------------------------
   localparam logic [31:0] ADDR_HEO_KEY      = 32'hf000_03b4;
   localparam logic [31:0] ADDR_HEO_CFG      = 32'hf000_03bc;
   localparam logic [31:0] ADDR_OVR1_CFG     = 32'hf000_0190;
   localparam logic [31:0] ADDR_CTRL         = 32'hf000_0400;
   localparam logic [31:0] ADDR_HEO_DEFAULT  = 32'hf000_0404;
   localparam logic [31:0] ADDR_OVR1_DEFAULT = 32'hf000_0408;
   localparam logic [31:0] ADDR_OVR1_KEY     = 32'hf000_040c;
   localparam logic [31:0] ADDR_STATUS       = 32'hf000_0410;

   // -------------------------------------------------------------------
   // Field layout of the blender configuration registers
   // -------------------------------------------------------------------
   localparam int KEY_MATCH_ENABLE_BIT     = 0;
   localparam int INVERT_OUTPUT_ENABLE_BIT = 1;
   localparam int ITERATED_TO_ADDER_BIT    = 2;
   localparam int USE_ITERATED_COLOUR_BIT  = 3;
   localparam int REVERSE_ALPHA_BIT        = 4;
   localparam int GLOBAL_ALPHA_ENABLE_BIT  = 5;
   localparam int LOCAL_ALPHA_ENABLE_BIT   = 6;
   localparam int LAYER_PIXEL_SELECT_BIT   = 7;
   localparam int DMA_LAYER_ENABLE_BIT     = 8;
   localparam int GLOBAL_ALPHA_VALUE_LSB   = 16;

   // Key fields
   localparam int RED_KEY_REF_LSB   = 16;
   localparam int GREEN_KEY_REF_LSB = 8;
   localparam int BLUE_KEY_REF_LSB  = 0;

   // Pixel layout: alpha, red, green, blue
   localparam int PIX_ALPHA_LSB = 24;
   localparam int PIX_RED_LSB   = 16;
   localparam int PIX_GREEN_LSB = 8;
   localparam int PIX_BLUE_LSB  = 0;

   // Status and control fields
   localparam int STAT_IN_VALID_BIT  = 0;
   localparam int STAT_OUT_VALID_BIT = 1;
   localparam int STAT_MATCH_BIT     = 2;
   localparam int STAT_COUNT_LSB     = 16;
   localparam int CTRL_ACTIVE_BIT    = 0;

   // -------------------------------------------------------------------
   // Masks, reset values, sizes
   // -------------------------------------------------------------------
   localparam logic [31:0] CFG_MASK   = 32'h00ff_17ff;
   localparam logic [31:0] KEY_MASK   = 32'h00ff_ffff;
   localparam logic [31:0] CTRL_MASK  = 32'h0000_0001;
   localparam logic [31:0] REG_RESET  = 32'h0000_0000;
   localparam logic [7:0]  ALPHA_FULL = 8'hff;
   localparam int          PIX_W      = 32;
   localparam int          COLOUR_W   = 24;
   localparam int          FIFO_DEPTH = 16;

endpackage

// ===== olb_fifo.sv
// Pixel FIFO with a registered output word
`timescale 1ns/1ps
module olb_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 16
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr;
      logic [AW-1:0]           rd;
      logic [CW-1:0]           count;
      logic                    full;
      logic                    ov;
      logic [W-1:0]            od;
   } olb_fifo_s;

   olb_fifo_s st;
   olb_fifo_s next_st;

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb
   begin
      logic push;
      logic bypass;
      push    = in_valid && !st.full;
      bypass  = 1'b0;
      next_st = st;
      if (!st.ov || out_ready)
      begin
         if (st.count != '0)
         begin
            next_st.od    = st.mem[st.rd];
            next_st.ov    = 1'b1;
            next_st.rd    = st.rd + 1'b1;
            next_st.count = next_st.count - 1'b1;
         end
         else if (push)
         begin
            next_st.od = in_data;
            next_st.ov = 1'b1;
            bypass     = 1'b1;
         end
         else
         begin
            next_st.ov = 1'b0;
         end
      end
      if (push && !bypass)
      begin
         next_st.mem[st.wr] = in_data;
         next_st.wr         = st.wr + 1'b1;
         next_st.count      = next_st.count + 1'b1;
      end
      next_st.full = (next_st.count == FULL_COUNT);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st <= '0;
      else
         st <= next_st;
   end

   assign in_ready  = !st.full;
   assign out_valid = st.ov;
   assign out_data  = st.od;

endmodule

// ===== olb_blender.sv
// Overlay layer blender with AHB-Lite configuration registers
`timescale 1ns/1ps
module olb_blender (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        use_iterated_colour_valid,
   output logic             use_iterated_colour_ready,
   input  wire logic [23:0] use_iterated_colour_data,
   input  wire logic        dma_valid,
   output logic             dma_ready,
   input  wire logic [31:0] dma_data,
   output logic             dma_fetch_enable,
   output logic             pix_out_valid,
   input  wire logic        pix_out_ready,
   output logic [23:0]      pix_out_data
);

   typedef struct packed {
      logic [31:0] key_heo;
      logic [31:0] cfg_heo;
      logic [31:0] cfg_ovr1;
      logic [31:0] key_ovr1;
      logic [31:0] def_heo;
      logic [31:0] def_ovr1;
      logic        active_layer;
      logic        dsel;
      logic        dwrite;
      logic [31:0] daddr;
      logic [31:0] rdata;
      logic        readyout;
      logic        resp;
      logic        in_valid;
      logic [23:0] in_data;
      logic        out_valid;
      logic [23:0] out_data;
      logic        last_match;
      logic [15:0] pix_count;
      logic        fetch_en;
   } olb_state_s;

   olb_state_s st;
   olb_state_s next_st;

   logic        fifo_valid;
   logic [31:0] fifo_data;
   logic        fifo_pop;
   logic        fire;
   logic [31:0] cfg;
   logic [31:0] key;
   logic [31:0] ovr_pix;
   logic [7:0]  alpha_eff;
   logic        match;
   logic [23:0] blended;

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic [7:0] olb_alpha(input logic ga_en, input logic la_en, input logic rev,
                                            input logic [7:0] ga, input logic [7:0] la);
      logic [15:0] prod;
      logic [7:0]  a;
      prod = {8'h00, ga} * {8'h00, la};
      if (ga_en && la_en)
         a = prod[15:8];
      else if (ga_en)
         a = ga;
      else if (la_en)
         a = la;
      else
         a = olb_pkg::ALPHA_FULL;
      return rev ? ~a : a;
   endfunction

   function automatic logic [7:0] olb_blend_comp(input logic [7:0] layer_pixel_select, input logic [7:0] use_iterated_colour,
                                                 input logic [7:0] a, input logic use_use_iterated_colour,
                                                 input logic to_adder);
      logic [7:0]         sub;
      logic [7:0]         add;
      logic [15:0]        po;
      logic [15:0]        ps;
      logic signed [18:0] sum;
      sub = use_use_iterated_colour ? use_iterated_colour : 8'h00;
      add = to_adder ? use_iterated_colour : 8'h00;
      po  = {8'h00, layer_pixel_select} * {8'h00, a};
      ps  = {8'h00, sub} * {8'h00, a};
      sum = $signed({3'b000, add, 8'h00}) + $signed({3'b000, po}) - $signed({3'b000, ps});
      if (sum < 0)
         return 8'h00;
      else if (sum[18:16] != 3'b000)
         return 8'hff;
      else
         return sum[15:8];
   endfunction

   function automatic logic [31:0] olb_read(input olb_state_s s, input logic [31:0] addr);
      logic [31:0] status;
      status                                 = '0;
      status[olb_pkg::STAT_IN_VALID_BIT]     = s.in_valid;
      status[olb_pkg::STAT_OUT_VALID_BIT]    = s.out_valid;
      status[olb_pkg::STAT_MATCH_BIT]        = s.last_match;
      status[olb_pkg::STAT_COUNT_LSB +: 16]  = s.pix_count;
      case (addr)
         olb_pkg::ADDR_HEO_KEY:      return s.key_heo;
         olb_pkg::ADDR_HEO_CFG:      return s.cfg_heo;
         olb_pkg::ADDR_OVR1_CFG:     return s.cfg_ovr1;
         olb_pkg::ADDR_OVR1_KEY:     return s.key_ovr1;
         olb_pkg::ADDR_HEO_DEFAULT:  return s.def_heo;
         olb_pkg::ADDR_OVR1_DEFAULT: return s.def_ovr1;
         olb_pkg::ADDR_CTRL:         return {31'h0000_0000, s.active_layer};
         olb_pkg::ADDR_STATUS:       return status;
         default:                    return 32'h0000_0000;
      endcase
   endfunction

   // -------------------------------------------------------------------
   // Pixel FIFO
   // -------------------------------------------------------------------
   olb_fifo #(
      .W     (olb_pkg::PIX_W),
      .DEPTH (olb_pkg::FIFO_DEPTH)
   ) u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (dma_valid),
      .in_ready  (dma_ready),
      .in_data   (dma_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // -------------------------------------------------------------------
   // Blend datapath
   // -------------------------------------------------------------------
   always_comb
   begin
      cfg = st.active_layer ? st.cfg_heo : st.cfg_ovr1;
      key = st.active_layer ? st.key_heo : st.key_ovr1;
      // Stream pixel only when the layer fetches and selects it
      ovr_pix = (cfg[olb_pkg::LAYER_PIXEL_SELECT_BIT] && cfg[olb_pkg::DMA_LAYER_ENABLE_BIT])
              ? fifo_data : (st.active_layer ? st.def_heo : st.def_ovr1);
      alpha_eff = olb_alpha(cfg[olb_pkg::GLOBAL_ALPHA_ENABLE_BIT],
                            cfg[olb_pkg::LOCAL_ALPHA_ENABLE_BIT],
                            cfg[olb_pkg::REVERSE_ALPHA_BIT],
                            cfg[olb_pkg::GLOBAL_ALPHA_VALUE_LSB +: 8],
                            ovr_pix[olb_pkg::PIX_ALPHA_LSB +: 8]);
      match = cfg[olb_pkg::KEY_MATCH_ENABLE_BIT]
           && ovr_pix[olb_pkg::PIX_RED_LSB +: 8]   == key[olb_pkg::RED_KEY_REF_LSB +: 8]
           && ovr_pix[olb_pkg::PIX_GREEN_LSB +: 8] == key[olb_pkg::GREEN_KEY_REF_LSB +: 8]
           && ovr_pix[olb_pkg::PIX_BLUE_LSB +: 8]  == key[olb_pkg::BLUE_KEY_REF_LSB +: 8];
      for (int c = 0; c < 3; c++)
      begin
         blended[c*8 +: 8] = olb_blend_comp(ovr_pix[c*8 +: 8], st.in_data[c*8 +: 8], alpha_eff,
                                            cfg[olb_pkg::USE_ITERATED_COLOUR_BIT],
                                            cfg[olb_pkg::ITERATED_TO_ADDER_BIT]);
      end
      fire     = st.in_valid && (!cfg[olb_pkg::DMA_LAYER_ENABLE_BIT] || fifo_valid)
              && (!st.out_valid || pix_out_ready);
      fifo_pop = fire && cfg[olb_pkg::DMA_LAYER_ENABLE_BIT];
   end

   // -------------------------------------------------------------------
   // Next state: bus slave and pixel stages
   // -------------------------------------------------------------------
   always_comb
   begin
      next_st          = st;
      next_st.readyout = 1'b1;
      next_st.resp     = 1'b0;
      if (st.dsel && st.dwrite)
      begin
         case (st.daddr)
            olb_pkg::ADDR_HEO_KEY:      next_st.key_heo      = hwdata & olb_pkg::KEY_MASK;
            olb_pkg::ADDR_HEO_CFG:      next_st.cfg_heo      = hwdata & olb_pkg::CFG_MASK;
            olb_pkg::ADDR_OVR1_CFG:     next_st.cfg_ovr1     = hwdata & olb_pkg::CFG_MASK;
            olb_pkg::ADDR_OVR1_KEY:     next_st.key_ovr1     = hwdata & olb_pkg::KEY_MASK;
            olb_pkg::ADDR_HEO_DEFAULT:  next_st.def_heo      = hwdata;
            olb_pkg::ADDR_OVR1_DEFAULT: next_st.def_ovr1     = hwdata;
            olb_pkg::ADDR_CTRL:         next_st.active_layer = hwdata[olb_pkg::CTRL_ACTIVE_BIT];
            default:                    next_st.dsel         = st.dsel;
         endcase
      end
      next_st.dsel   = hsel && htrans[1] && hready;
      next_st.dwrite = hwrite;
      next_st.daddr  = haddr;
      // Reads see a write still in its data phase
      if (hsel && htrans[1] && hready && !hwrite)
         next_st.rdata = olb_read(next_st, haddr);
      if (st.out_valid && pix_out_ready)
         next_st.out_valid = 1'b0;
      if (fire)
      begin
         next_st.out_valid  = 1'b1;
         next_st.in_valid   = 1'b0;
         next_st.last_match = match;
         next_st.pix_count  = st.pix_count + 16'h0001;
         if (match)
            next_st.out_data = st.in_data;
         else if (cfg[olb_pkg::INVERT_OUTPUT_ENABLE_BIT])
            next_st.out_data = ~blended;
         else
            next_st.out_data = blended;
      end
      if (!st.in_valid && use_iterated_colour_valid)
      begin
         next_st.in_valid = 1'b1;
         next_st.in_data  = use_iterated_colour_data;
      end
      next_st.fetch_en = next_st.active_layer ? next_st.cfg_heo[olb_pkg::DMA_LAYER_ENABLE_BIT]
                                              : next_st.cfg_ovr1[olb_pkg::DMA_LAYER_ENABLE_BIT];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st          <= '0;
         st.readyout <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign hreadyout        = st.readyout;
   assign hrdata           = st.rdata;
   assign hresp            = st.resp;
   assign use_iterated_colour_ready       = !st.in_valid;
   assign dma_fetch_enable = st.fetch_en;
   assign pix_out_valid    = st.out_valid;
   assign pix_out_data     = st.out_data;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   AST_KEY_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && !cfg[olb_pkg::KEY_MATCH_ENABLE_BIT] |=> !st.last_match && pix_out_valid)
      else $error("key match reported with keying off");

   AST_INVERT: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && !match && cfg[olb_pkg::INVERT_OUTPUT_ENABLE_BIT] |=> pix_out_data == ~$past(blended))
      else $error("inverted output not the complement of the blend");

   AST_ZERO_ALPHA: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && !match && cfg[8:0] == 9'h020 && cfg[23:16] == 8'h00 |=> pix_out_data == 24'h000000)
      else $error("zero alpha without adder operand must give black");

   AST_REV_FULL: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && !match && cfg[6:4] == 3'b001 && cfg[1] == 1'b0 && cfg[2]
      |=> pix_out_data == $past(st.in_data))
      else $error("reversed full alpha must pass the adder operand");

   AST_NO_USE_ITERATED_COLOUR: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && !match && cfg[6:1] == 6'b000000 |=> pix_out_data[7:0] <= $past(ovr_pix[7:0]))
      else $error("difference term not zero with iterated colour off");

   AST_ALPHA_NONE: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg[6:4] == 3'b000 |-> alpha_eff == olb_pkg::ALPHA_FULL)
      else $error("alpha not full with both coefficients off");

   AST_GLOBAL_ALPHA: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg[6:4] == 3'b010 |-> alpha_eff == cfg[olb_pkg::GLOBAL_ALPHA_VALUE_LSB +: 8])
      else $error("global alpha not taken from its field");

   AST_FETCH: assert property (@(posedge hclk) disable iff (!hresetn)
      fire
      |-> fifo_pop == cfg[olb_pkg::DMA_LAYER_ENABLE_BIT]
          && dma_fetch_enable == cfg[olb_pkg::DMA_LAYER_ENABLE_BIT])
      else $error("stream pop disagrees with the fetch enable");

   AST_TRANSPARENT: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && match |=> pix_out_data == $past(st.in_data) && st.last_match)
      else $error("keyed pixel did not pass the iterated pixel");

   AST_DEFAULT: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg[olb_pkg::LAYER_PIXEL_SELECT_BIT] |-> ovr_pix == (st.active_layer ? st.def_heo : st.def_ovr1))
      else $error("default colour not used with the layer pixel off");

endmodule

// ===== olb_partner.sv
// Far-side model: iterated and DMA pixel sources, output pixel sink
`timescale 1ns/1ps
module olb_partner (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        slow,
   output logic             use_iterated_colour_valid,
   input  wire logic        use_iterated_colour_ready,
   output logic [23:0]      use_iterated_colour_data,
   output logic             dma_valid,
   input  wire logic        dma_ready,
   output logic [31:0]      dma_data,
   input  wire logic        dma_fetch_enable,
   input  wire logic        pix_out_valid,
   output logic             pix_out_ready,
   input  wire logic [23:0] pix_out_data
);
   logic [23:0] iq[$];
   logic [31:0] dq[$];
   logic [23:0] rq[$];
   int          ii = 0;
   int          di = 0;
   // Released data lines alternate each cycle between the last word and its inverse
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         use_iterated_colour_valid    <= 1'b0;
         use_iterated_colour_data     <= 24'h000000;
         dma_valid     <= 1'b0;
         dma_data      <= 32'h00000000;
         pix_out_ready <= 1'b0;
      end
      else
      begin
         if (use_iterated_colour_valid && use_iterated_colour_ready)
            ii = ii + 1;
         if (dma_valid && dma_ready)
            di = di + 1;
         if (pix_out_valid && pix_out_ready)
            rq.push_back(pix_out_data);
         use_iterated_colour_valid    <= ii < iq.size();
         use_iterated_colour_data     <= (ii < iq.size()) ? iq[ii] : ~use_iterated_colour_data;
         dma_valid     <= dma_fetch_enable && di < dq.size();
         dma_data      <= (di < dq.size()) ? dq[di] : ~dma_data;
         pix_out_ready <= slow ? ~pix_out_ready : 1'b1;
      end
   end
endmodule

// ===== olb_blender_tb_top.sv
// Testbench: register access, blending cases and FIFO fill of the overlay blender
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("Error %s: expected %h, seen %h", name, exp, got); \
      end \
   end
module olb_blender_tb_top;
   logic        hclk, hresetn, hwrite, hreadyout, hresp, slow;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd, dma_data;
   logic        use_iterated_colour_valid, use_iterated_colour_ready, dma_valid, dma_ready, dma_fetch_enable, pix_out_valid, pix_out_ready;
   logic [23:0] use_iterated_colour_data, pix_out_data, got;
   int          n_mismatch = 0;
   int          checks = 0;
   localparam logic [23:0] IT = 24'h30a0f0;
   localparam logic [23:0] DF = 24'h112233;
   localparam logic [23:0] KY = 24'h5ac37e;
   localparam logic [31:0] CFG_TAB [14] = '{32'h00000000, 32'h00800020, 32'h000001c0, 32'h008001e0,
      32'h00800034, 32'h0000018c, 32'h00000102, 32'h00000181, 32'h00000181, 32'h00000181,
      32'h00000181, 32'h00ff0039, 32'h00000020, 32'h00000014};
   localparam logic [31:0] DMA_TAB [14] = '{32'h0, 32'h0, 32'h60123456, 32'hc0abcdef, 32'h0, 32'h40fedc10,
      32'h77777777, {8'h20, KY}, {8'h20, KY ^ 24'h010000}, {8'h20, KY ^ 24'h000100},
      {8'h20, KY ^ 24'h000001}, 32'h0, 32'h0, 32'h0};

   olb_blender dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .use_iterated_colour_valid(use_iterated_colour_valid), .use_iterated_colour_ready(use_iterated_colour_ready),
      .use_iterated_colour_data(use_iterated_colour_data), .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data),
      .dma_fetch_enable(dma_fetch_enable), .pix_out_valid(pix_out_valid),
      .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data));
   olb_partner far (.hclk(hclk), .hresetn(hresetn), .slow(slow), .use_iterated_colour_valid(use_iterated_colour_valid),
      .use_iterated_colour_ready(use_iterated_colour_ready), .use_iterated_colour_data(use_iterated_colour_data), .dma_valid(dma_valid), .dma_ready(dma_ready),
      .dma_data(dma_data), .dma_fetch_enable(dma_fetch_enable), .pix_out_valid(pix_out_valid),
      .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data));

   initial hclk = 1'b0;
   always #2.5 hclk = ~hclk;

   // ------------------------------------------------------------------
   // Bus access, called right after a rising edge
   // ------------------------------------------------------------------
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
      `CHECK("hresp", 1'b0, hresp)
   endtask

   task automatic wait_out(input int n);
      int k;
      k = 0;
      while (far.rq.size() < n && k < 400)
      begin
         @(posedge hclk);
         k++;
      end
      `CHECK("output count", 1'b1, far.rq.size() >= n)
   endtask

   // ------------------------------------------------------------------
   // Expected pixel
   // ------------------------------------------------------------------
   function automatic logic [23:0] exp_pix(input logic [31:0] c, input logic [31:0] dm);
      logic [23:0] o;
      logic [23:0] r;
      int          a;
      int          v;
      o = (c[7] && c[8]) ? dm[23:0] : DF;
      if (c[0] && o == KY)
         return IT;
      a = 255;
      if (c[5] && c[6])
         a = (int'(c[23:16]) * int'(dm[31:24])) >> 8;
      else if (c[5])
         a = int'(c[23:16]);
      else if (c[6])
         a = int'(dm[31:24]);
      if (c[4])
         a = 255 - a;
      for (int k = 0; k < 3; k++)
      begin
         v = ((c[2] ? int'(IT[k*8+:8]) : 0) * 256 + int'(o[k*8+:8]) * a
              - (c[3] ? int'(IT[k*8+:8]) : 0) * a) >>> 8;
         r[k*8+:8] = (v < 0) ? 8'h00 : (v > 255) ? 8'hff : v[7:0];
      end
      return c[1] ? ~r : r;
   endfunction

   task automatic close_out;
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      close_out();
   end

   initial
   begin
      logic [31:0] adr [9];
      logic [31:0] c;
      adr = '{olb_pkg::ADDR_HEO_KEY, olb_pkg::ADDR_HEO_CFG, olb_pkg::ADDR_OVR1_CFG, olb_pkg::ADDR_CTRL,
         olb_pkg::ADDR_HEO_DEFAULT, olb_pkg::ADDR_OVR1_DEFAULT, olb_pkg::ADDR_OVR1_KEY,
         olb_pkg::ADDR_STATUS, 32'hf0000500};
      hresetn = 1'b0;
      haddr = 32'h0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hwdata = 32'h0;
      slow = 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset values, unmapped place, reserved bits
      foreach (adr[i])
      begin
         bus(1'b0, adr[i], 32'h0, rd);
         `CHECK("reset value", olb_pkg::REG_RESET, rd)
      end
      bus(1'b1, 32'hf0000500, 32'hffffffff, rd);
      bus(1'b0, 32'hf0000500, 32'h0, rd);
      `CHECK("unmapped", 32'h0, rd)
      bus(1'b1, olb_pkg::ADDR_HEO_KEY, 32'hffffffff, rd);
      bus(1'b0, olb_pkg::ADDR_HEO_KEY, 32'h0, rd);
      `CHECK("key mask", olb_pkg::KEY_MASK, rd)
      // Blending cases, even on the high-end layer, odd on overlay one
      for (int i = 0; i < 14; i++)
      begin
         c = CFG_TAB[i];
         bus(1'b1, olb_pkg::ADDR_CTRL, {31'h0, ~i[0]}, rd);
         bus(1'b1, i[0] ? olb_pkg::ADDR_OVR1_KEY : olb_pkg::ADDR_HEO_KEY, {8'h0, KY}, rd);
         bus(1'b1, i[0] ? olb_pkg::ADDR_OVR1_DEFAULT : olb_pkg::ADDR_HEO_DEFAULT, {8'h0, DF}, rd);
         bus(1'b1, i[0] ? olb_pkg::ADDR_OVR1_CFG : olb_pkg::ADDR_HEO_CFG, c, rd);
         bus(1'b0, i[0] ? olb_pkg::ADDR_OVR1_CFG : olb_pkg::ADDR_HEO_CFG, 32'h0, rd);
         `CHECK("config readback", c & olb_pkg::CFG_MASK, rd)
         `CHECK("fetch enable", c[8], dma_fetch_enable)
         if (c[8])
            far.dq.push_back(DMA_TAB[i]);
         far.iq.push_back(IT);
         wait_out(1);
         got = far.rq.pop_front();
         `CHECK("blended pixel", exp_pix(c, DMA_TAB[i]), got)
         bus(1'b0, olb_pkg::ADDR_STATUS, 32'h0, rd);
         `CHECK("keyed flag", (i == 7), rd[olb_pkg::STAT_MATCH_BIT])
      end
      // Fill the pixel FIFO, then drain it against a stalling sink
      bus(1'b1, olb_pkg::ADDR_CTRL, 32'h1, rd);
      bus(1'b1, olb_pkg::ADDR_HEO_CFG, 32'h000001c0, rd);
      slow <= 1'b1;
      for (int k = 0; k < 20; k++)
         far.dq.push_back({8'(k * 13), 24'(k * 24'h010203)});
      repeat (60) @(posedge hclk);
      `CHECK("fifo full", 1'b0, dma_ready)
      repeat (20) far.iq.push_back(IT);
      wait_out(20);
      for (int k = 0; k < 20; k++)
      begin
         got = far.rq.pop_front();
         `CHECK("drained pixel", exp_pix(32'h000001c0, {8'(k * 13), 24'(k * 24'h010203)}), got)
      end
      `CHECK("fifo empty", 1'b1, dma_ready)
      close_out();
   end
endmodule
